// file: logic/link_pkg.sv
// Shared constants for the serial link framing and lock tracking block.
package link_pkg;

  // Word and symbol widths: one data word plus a start and a stop clock bit.
  localparam int WORD_W = 10;
  localparam int SYM_W = 12;
  localparam int IRQ_W = 3;

  // Payload sent instead of data while training is requested.
  localparam logic [9:0] TRAINING_PATTERN = 10'h01f;

  // Training burst length and the lock thresholds, in symbols.
  localparam logic [10:0] TRAIN_BURST_SYMS = 11'h400;
  localparam int LOSS_INVALID_SYMS = 4;
  localparam int LOCK_TRAIN_SYMS = 4;
  localparam int LOCK_RANDOM_SYMS = 32;

  // Timing: system clock period, recovered clock half period and reference clock timeout.
  localparam int SYS_PERIOD_NS = 100;
  localparam int RXCLK_HALF_NS = 400;
  localparam int RECEIVER_REFERENCE_CLOCK_TIMEOUT_NS = 1600;
  localparam int RXCLK_HALF_CYC = (RXCLK_HALF_NS / SYS_PERIOD_NS) < 1 ? 1 : (RXCLK_HALF_NS / SYS_PERIOD_NS);
  localparam int RECEIVER_REFERENCE_CLOCK_TIMEOUT_CYC = (RECEIVER_REFERENCE_CLOCK_TIMEOUT_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // Register byte offsets.
  localparam logic [3:0] REG_IRQ_STATUS = 4'h0;
  localparam logic [3:0] REG_IRQ_CLEAR = 4'h4;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h8;
  localparam logic [3:0] REG_LINK_STATE = 4'hc;
  localparam logic [2:0] IRQ_ENABLE_RST = 3'h0;

  // Interrupt bit positions.
  localparam int IRQ_LOCK_GAINED = 0;
  localparam int IRQ_LOCK_DROPPED = 1;
  localparam int IRQ_BURST_DONE = 2;

  // Positions of the synchronised pins within the pin vector.
  localparam int PIN_WORD = 0;
  localparam int PIN_TX_CLK = 10;
  localparam int PIN_TX_SEL = 11;
  localparam int PIN_REQ_A = 12;
  localparam int PIN_REQ_B = 13;
  localparam int PIN_RECEIVER_REFERENCE_CLOCK = 14;
  localparam int PIN_RX_SEL = 15;
  localparam int PIN_RX_EN = 16;
  localparam int PIN_N = 17;

endpackage

// file: logic/tx_symbol_framer.sv
// Transmit framer: wraps each word in clock bits and runs training bursts.
module tx_symbol_framer (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Captured word
  input wire logic i_word_stb,
  input wire logic [link_pkg::WORD_W-1:0] i_word,
  input wire logic i_pattern_request,
  // Symbol towards the link
  output logic [link_pkg::SYM_W-1:0] o_symbol,
  output logic o_symbol_valid,
  output logic o_training,
  output logic o_burst_done
);
  import link_pkg::*;

  logic req_prev_q;
  logic [10:0] remain_q;
  logic training;

  // Training runs while requested and until the minimum burst has gone out.
  assign training = i_pattern_request | (remain_q != 11'h000);

  // Each new request reloads the minimum burst, so a short pulse still trains fully.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      req_prev_q <= 1'b0;
      remain_q <= 11'h000;
    end else begin
      req_prev_q <= i_pattern_request;
      if (i_pattern_request && !req_prev_q) begin
        remain_q <= TRAIN_BURST_SYMS;
      end else if (i_word_stb && remain_q != 11'h000) begin
        remain_q <= remain_q - 11'h001;
      end
    end
  end

  // One symbol per word, start bit high and stop bit low for clock recovery.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_symbol <= 12'h000;
      o_symbol_valid <= 1'b0;
    end else begin
      o_symbol_valid <= i_word_stb;
      if (i_word_stb) begin
        o_symbol <= {1'b1, (training ? TRAINING_PATTERN : i_word), 1'b0};
      end
    end
  end

  // End of a training burst is reported as a one-cycle event.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_training <= 1'b0;
      o_burst_done <= 1'b0;
    end else begin
      o_training <= training;
      o_burst_done <= o_training & ~training;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  a_embedded_clock_bits: assert property (o_symbol_valid |-> o_symbol[SYM_W-1] && !o_symbol[0])
    else $error("symbol lacks its embedded clock bits");
  a_training_on_request: assert property (i_word_stb && i_pattern_request |=> o_symbol[SYM_W-2:1] == TRAINING_PATTERN)
    else $error("data sent while training was requested");
  a_burst_minimum: assert property ($rose(i_pattern_request) |=> remain_q == TRAIN_BURST_SYMS ##0 o_training)
    else $error("training burst not loaded to its minimum length");

endmodule

// file: logic/rx_lock_tracker.sv
// Receive lock tracker: acquires, holds and drops lock from symbol clock bits.
module rx_lock_tracker (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Symbols from the link
  input wire logic [link_pkg::SYM_W-1:0] i_symbol,
  input wire logic i_symbol_valid,
  input wire logic i_receiver_reference_clock_running,
  // Lock state and words
  output logic o_locked,
  output logic [link_pkg::WORD_W-1:0] o_word,
  output logic o_word_stb,
  output logic o_lock_gained,
  output logic o_lock_dropped
);
  import link_pkg::*;

  typedef enum logic {ST_UNLOCKED, ST_LOCKED} lock_state_t;

  lock_state_t state_q;
  logic [4:0] good_q;
  logic [2:0] train_q;
  logic [2:0] bad_q;
  logic sym_ok;
  logic is_train;

  // Start bit high and stop bit low mark valid embedded clock information.
  function automatic logic clock_bits_ok(input logic [SYM_W-1:0] sym);
    clock_bits_ok = sym[SYM_W-1] & ~sym[0];
  endfunction

  assign sym_ok = clock_bits_ok(i_symbol);
  assign is_train = (i_symbol[SYM_W-2:1] == TRAINING_PATTERN);
  assign o_locked = (state_q == ST_LOCKED);

  // Lock acquisition and loss; the acquisition counts restart whenever the reference clock stops.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_UNLOCKED;
      good_q <= 5'h00;
      train_q <= 3'h0;
      bad_q <= 3'h0;
    end else begin
      case (state_q)
        ST_UNLOCKED: begin
          if (i_symbol_valid && sym_ok && i_receiver_reference_clock_running) begin
            good_q <= good_q + 5'h01;
            train_q <= is_train ? train_q + 3'h1 : 3'h0;
            if ((is_train && train_q == 3'(LOCK_TRAIN_SYMS - 1)) || good_q == 5'(LOCK_RANDOM_SYMS - 1)) begin
              state_q <= ST_LOCKED;
              good_q <= 5'h00;
              train_q <= 3'h0;
            end
          end else if (i_symbol_valid || !i_receiver_reference_clock_running) begin
            good_q <= 5'h00;
            train_q <= 3'h0;
          end
        end
        ST_LOCKED: begin
          if (i_symbol_valid && !sym_ok) begin
            bad_q <= bad_q + 3'h1;
            if (bad_q == 3'(LOSS_INVALID_SYMS - 1)) begin
              state_q <= ST_UNLOCKED;
              bad_q <= 3'h0;
            end
          end else if (i_symbol_valid) begin
            bad_q <= 3'h0;
          end
        end
        default: state_q <= ST_UNLOCKED;
      endcase
    end
  end

  // Words go out only while locked; the last few before a loss stay suspect downstream.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_word <= 10'h000;
      o_word_stb <= 1'b0;
    end else begin
      o_word_stb <= o_locked & i_symbol_valid & sym_ok;
      if (o_locked && i_symbol_valid && sym_ok) begin
        o_word <= i_symbol[SYM_W-2:1];
      end
    end
  end

  // Lock changes as one-cycle events.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_lock_gained <= 1'b0;
      o_lock_dropped <= 1'b0;
    end else begin
      o_lock_gained <= (state_q == ST_UNLOCKED) && i_symbol_valid && sym_ok && i_receiver_reference_clock_running &&
                       ((is_train && train_q == 3'(LOCK_TRAIN_SYMS - 1)) || good_q == 5'(LOCK_RANDOM_SYMS - 1));
      o_lock_dropped <= o_locked && i_symbol_valid && !sym_ok && bad_q == 3'(LOSS_INVALID_SYMS - 1);
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_bad_locked;
    o_locked && i_symbol_valid && !clock_bits_ok(i_symbol);
  endsequence

  a_unlock_on_fourth: assert property (s_bad_locked ##0 bad_q == 3'(LOSS_INVALID_SYMS - 1) |=> !o_locked ##1 !o_locked)
    else $error("lock kept after four invalid symbols");
  a_no_early_unlock: assert property (s_bad_locked ##0 bad_q < 3'(LOSS_INVALID_SYMS - 1) |=> o_locked)
    else $error("lock dropped before four invalid symbols");
  a_lock_needs_receiver_reference_clock: assert property ($rose(o_locked) |-> $past(i_receiver_reference_clock_running) && o_lock_gained)
    else $error("lock taken without a running reference clock");
  a_lock_cause: assert property ($rose(o_locked) |-> $past(train_q) == 3'(LOCK_TRAIN_SYMS - 1)
                                 || $past(good_q) == 5'(LOCK_RANDOM_SYMS - 1))
    else $error("lock taken without enough good symbols");
  a_word_while_locked: assert property (o_word_stb |-> o_locked && $past(o_locked))
    else $error("word delivered while unlocked");

endmodule

// file: logic/serial_link_lock_sync.sv
// Top of the serial link framing, synchronisation and lock tracking block.
// Summary of operation
// - Each 10-bit transmit word becomes one symbol carrying two embedded clock bits.
// - The receiver acquires lock only while its reference clock is seen running.
// - After reset the receive outputs stay disabled until lock is reached.
// - Training patterns replace data while either pattern request is high.
// - The lock indicator is high while unlocked and low once locked.
// - Lock is dropped only after four consecutive symbols with bad clock bits.
// - Lock can be acquired from random data without training, only slower.
// - While the lock indicator is low the parallel outputs carry valid words.
// - Relock comes from resent training patterns or from random-data lock.
// - Each request sends at least 1024 training symbols, the two requests ORed.
// - Parallel outputs and recovered clock are disabled while the indicator is high.
// - A low receive output enable disables the parallel outputs and recovered clock.
// - Each edge select picks the rising edge when high and the falling edge when low.
//
// Decided for this implementation: the register addresses and the plain strobed port.
module serial_link_lock_sync (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Transmit pins
  input wire logic [link_pkg::WORD_W-1:0] i_parallel_word_in,
  input wire logic i_transmit_word_clock,
  input wire logic i_tx_edge_select,
  input wire logic i_pattern_request_a,
  input wire logic i_pattern_request_b,
  // Serial symbol towards the partner
  output logic [link_pkg::SYM_W-1:0] o_link_symbol,
  output logic o_link_symbol_valid,
  // Serial symbol from the partner
  input wire logic [link_pkg::SYM_W-1:0] i_link_symbol,
  input wire logic i_link_symbol_valid,
  // Receive pins
  input wire logic i_receiver_reference_clock,
  input wire logic i_rx_edge_select,
  input wire logic i_rx_output_enable,
  output logic o_lock_lost,
  output logic [link_pkg::WORD_W-1:0] o_parallel_word_out,
  output logic o_parallel_word_out_oe,
  output logic o_rx_word_clk,
  output logic o_rx_word_clk_oe,
  // Register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output logic o_irq
);
  import link_pkg::*;

  // Pin synchroniser stages and edge history.
  logic [PIN_N-1:0] pins_raw;
  logic [PIN_N-1:0] s1_q;
  logic [PIN_N-1:0] s2_q;
  logic [PIN_N-1:0] s3_q;
  logic [PIN_N-1:0] clean_q;
  logic [PIN_N-1:0] prev_q;

  // Transmit strobe and reference clock watch.
  logic tx_word_stb;
  logic receiver_reference_clock_edge;
  logic [4:0] receiver_reference_clock_idle_q;
  logic receiver_reference_clock_running;

  // Signals between the two halves and the pins.
  logic tx_training;
  logic tx_burst_done;
  logic rx_locked;
  logic rx_word_stb;
  logic rx_lock_gained;
  logic rx_lock_dropped;

  // Recovered clock, drive and software view.
  logic [2:0] rxclk_half_q;
  logic oe_q;
  logic [3:0] link_state;

  // Interrupt state.
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_enable_q;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_clear;

  // Write strobe aimed at one register; shared by every writable offset.
  function automatic logic wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] offset);
    wr_hit = wr & (addr == offset);
  endfunction

  // Active edge of a sampled clock as chosen by its edge select level.
  function automatic logic active_edge(input logic cur, input logic prev, input logic rise_sel);
    active_edge = rise_sel ? (cur & ~prev) : (~cur & prev);
  endfunction

  assign pins_raw = {i_rx_output_enable, i_rx_edge_select, i_receiver_reference_clock,
                     i_pattern_request_b, i_pattern_request_a, i_tx_edge_select,
                     i_transmit_word_clock, i_parallel_word_in};

  // Every pin passes three flops; a change is accepted once stages two and three agree.
  for (genvar g = 0; g < PIN_N; g++) begin : g_pin_sync
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        s1_q[g] <= 1'b0;
        s2_q[g] <= 1'b0;
        s3_q[g] <= 1'b0;
        clean_q[g] <= 1'b0;
        prev_q[g] <= 1'b0;
      end else begin
        s1_q[g] <= pins_raw[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g]) begin
          clean_q[g] <= s3_q[g];
        end
        prev_q[g] <= clean_q[g];
      end
    end
  end

  // Word data is filtered in step with the word clock, so it is stable at the strobe.
  assign tx_word_stb = active_edge(clean_q[PIN_TX_CLK], prev_q[PIN_TX_CLK], clean_q[PIN_TX_SEL]);
  assign receiver_reference_clock_edge = clean_q[PIN_RECEIVER_REFERENCE_CLOCK] ^ prev_q[PIN_RECEIVER_REFERENCE_CLOCK];
  assign receiver_reference_clock_running = (receiver_reference_clock_idle_q != 5'(RECEIVER_REFERENCE_CLOCK_TIMEOUT_CYC));

  // The reference clock counts as stopped once no edge is seen for the timeout.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      receiver_reference_clock_idle_q <= 5'(RECEIVER_REFERENCE_CLOCK_TIMEOUT_CYC);
    end else if (receiver_reference_clock_edge) begin
      receiver_reference_clock_idle_q <= 5'h00;
    end else if (receiver_reference_clock_running) begin
      receiver_reference_clock_idle_q <= receiver_reference_clock_idle_q + 5'h01;
    end
  end

  // Transmit side; the two requests are ORed, one of them usually fed from the lock indicator.
  tx_symbol_framer u_tx (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_word_stb(tx_word_stb),
    .i_word(clean_q[PIN_WORD +: WORD_W]),
    .i_pattern_request(clean_q[PIN_REQ_A] | clean_q[PIN_REQ_B]),
    .o_symbol(o_link_symbol),
    .o_symbol_valid(o_link_symbol_valid),
    .o_training(tx_training),
    .o_burst_done(tx_burst_done)
  );

  // Receive side lock tracking and word recovery.
  rx_lock_tracker u_rx (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_symbol(i_link_symbol),
    .i_symbol_valid(i_link_symbol_valid),
    .i_receiver_reference_clock_running(receiver_reference_clock_running),
    .o_locked(rx_locked),
    .o_word(o_parallel_word_out),
    .o_word_stb(rx_word_stb),
    .o_lock_gained(rx_lock_gained),
    .o_lock_dropped(rx_lock_dropped)
  );

  // Indicator is high from reset until lock, and again after any loss.
  assign o_lock_lost = ~rx_locked;

  // Recovered clock: inactive level just after each word, active edge half a word later.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_word_clk <= 1'b0;
      rxclk_half_q <= 3'h0;
    end else if (rx_word_stb) begin
      o_rx_word_clk <= ~clean_q[PIN_RX_SEL];
      rxclk_half_q <= 3'(RXCLK_HALF_CYC);
    end else if (rxclk_half_q != 3'h0) begin
      rxclk_half_q <= rxclk_half_q - 3'h1;
      if (rxclk_half_q == 3'h1) begin
        o_rx_word_clk <= clean_q[PIN_RX_SEL];
      end
    end
  end

  // Outputs are driven only while locked and enabled; reset leaves them disabled.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= rx_locked & clean_q[PIN_RX_EN];
    end
  end

  // A lock loss removes drive at once, without waiting for the registered enable.
  assign o_parallel_word_out_oe = oe_q & rx_locked;
  assign o_rx_word_clk_oe = oe_q & rx_locked;

  // Sticky interrupt status; a new event wins over a clear in the same cycle.
  assign irq_events = {tx_burst_done, rx_lock_dropped, rx_lock_gained};
  assign irq_clear = wr_hit(i_reg_wr, i_reg_addr, REG_IRQ_CLEAR) ? i_reg_wdata[IRQ_W-1:0] : 3'h0;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_status_q <= 3'h0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_events;
    end
  end

  // Interrupt enable register.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_enable_q <= IRQ_ENABLE_RST;
    end else if (wr_hit(i_reg_wr, i_reg_addr, REG_IRQ_ENABLE)) begin
      irq_enable_q <= i_reg_wdata[IRQ_W-1:0];
    end
  end

  // Level interrupt; masking a pending bit drops the line without losing the status.
  assign o_irq = |(irq_status_q & irq_enable_q);

  // Link state word as software reads it.
  assign link_state = {clean_q[PIN_RX_EN], tx_training, receiver_reference_clock_running, o_lock_lost};

  // Read data stands only in the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        REG_IRQ_STATUS: o_reg_rdata <= {29'h0000_0000, irq_status_q};
        REG_IRQ_ENABLE: o_reg_rdata <= {29'h0000_0000, irq_enable_q};
        REG_LINK_STATE: o_reg_rdata <= {28'h000_0000, link_state};
        default: o_reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  a_hiz_while_unlocked: assert property ($rose(o_lock_lost) |-> (!o_parallel_word_out_oe && !o_rx_word_clk_oe) [*3])
    else $error("outputs driven after lock was lost");
  a_disable_forces_z: assert property (!clean_q[PIN_RX_EN] |=> !o_parallel_word_out_oe && !o_rx_word_clk_oe)
    else $error("outputs driven while receive output enable is low");
  a_tx_edge_choice: assert property (tx_word_stb |-> clean_q[PIN_TX_CLK] == clean_q[PIN_TX_SEL]
                                     ##1 o_link_symbol_valid)
    else $error("word taken on the wrong transmit clock edge");
  a_irq_set_wins: assert property (irq_events[IRQ_LOCK_DROPPED] && irq_clear[IRQ_LOCK_DROPPED]
                                   |=> irq_status_q[IRQ_LOCK_DROPPED])
    else $error("interrupt event lost to a clear");

  // Recovered clock steps after a word; the select is taken as it stood at each step.
  sequence s_word_then_quiet;
    rx_word_stb ##1 !rx_word_stb [*5];
  endsequence

  sequence s_rxclk_inactive;
    o_rx_word_clk == !$past(clean_q[PIN_RX_SEL]);
  endsequence

  sequence s_rxclk_active;
    o_rx_word_clk == $past(clean_q[PIN_RX_SEL]);
  endsequence

  a_rxclk_inactive_level: assert property (rx_word_stb |=> s_rxclk_inactive)
    else $error("recovered clock not at its inactive level after a word");
  a_rxclk_active_edge: assert property (s_word_then_quiet |-> s_rxclk_active)
    else $error("recovered clock active edge missing half a word later");

  // Read data returns to zero unless a read was strobed, so no stale word is seen.
  a_rdata_one_cycle: assert property (!i_reg_rd |=> o_reg_rdata == 32'h0000_0000)
    else $error("read data held beyond its cycle");
  // The clear register is write only.
  a_clear_reads_zero: assert property (i_reg_rd && i_reg_addr == REG_IRQ_CLEAR |=> o_reg_rdata == 32'h0000_0000)
    else $error("clear register returned data");
  // A pending status bit stays until software clears it.
  a_status_sticky: assert property (irq_status_q[IRQ_LOCK_GAINED] && !irq_clear[IRQ_LOCK_GAINED]
                                    |=> irq_status_q[IRQ_LOCK_GAINED])
    else $error("pending interrupt vanished without a clear");
  a_drop_sets_status: assert property (rx_lock_dropped |=> irq_status_q[IRQ_LOCK_DROPPED])
    else $error("lock loss not recorded in status");

  // Drive needs lock now and in the cycle before, so no partial word reaches the pins.
  a_oe_needs_lock: assert property (o_parallel_word_out_oe |-> !o_lock_lost && $past(rx_locked))
    else $error("outputs driven without lock");
  a_drive_after_lock: assert property ($rose(rx_locked) && clean_q[PIN_RX_EN]
                                       |=> o_parallel_word_out_oe && o_rx_word_clk_oe)
    else $error("outputs not driven after lock");

  // A seen reference clock edge restarts the running window from the next cycle.
  a_receiver_reference_clock_seen: assert property (receiver_reference_clock_edge |=> receiver_reference_clock_running)
    else $error("reference clock edge not counted as running");
  a_training_shown: assert property (clean_q[PIN_REQ_A] || clean_q[PIN_REQ_B] |=> tx_training)
    else $error("training not reported while requested");

endmodule

// file: verification/link_partner.sv
// Behavioural model of the opposite chip across the serial link.
module link_partner (
  // Clock
  input wire logic i_sys_clk,
  // Symbols arriving from the block
  input wire logic [link_pkg::SYM_W-1:0] i_symbol,
  input wire logic i_symbol_valid,
  // Symbols sent to the block
  output logic [link_pkg::SYM_W-1:0] o_symbol,
  output logic o_symbol_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  import link_pkg::*;
  int train_cnt = 0;
  logic [SYM_W-1:0] last_sym = '0;

  // Records every symbol heard and counts the training ones for burst length checks.
  always @(posedge i_sys_clk) begin
    if (i_symbol_valid) begin
      last_sym <= i_symbol;
      if (i_symbol[10:1] == TRAINING_PATTERN) begin
        train_cnt <= train_cnt + 1;
      end
    end
  end

  initial begin
    o_symbol = '0;
    o_symbol_valid = 1'b0;
  end

  // Sends one symbol per word period; between symbols the line shows the inverse so stale data never looks valid.
  task automatic send(input logic [SYM_W-1:0] s);
    @(posedge i_sys_clk);
    o_symbol <= s;
    o_symbol_valid <= 1'b1;
    @(posedge i_sys_clk);
    o_symbol <= ~s;
    o_symbol_valid <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
  endtask

  // Restarts the training count before a burst; only called while no symbol is arriving.
  task automatic clear();
    train_cnt = 0;
  endtask
endmodule

// file: verification/serial_link_lock_sync_tb.sv
// Self-checking bench for the serial link framing and lock tracking block.
module serial_link_lock_sync_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import link_pkg::*;
  logic clk = 0, nrst = 0, wclk = 0, tx_sel = 1, req_a = 0, req_b = 0, receiver_reference_clock = 0, rx_sel = 1, rx_en = 1;
  logic ref_on = 0, tx_on = 0, vphase = 0, wr = 0, rd = 0;
  logic [WORD_W-1:0] word = 10'h2a5, w;
  logic [SYM_W-1:0] tx_sym, rx_sym;
  logic tx_vld, rx_vld, lock_lost, oe, rclk, rclk_oe, irq;
  logic [WORD_W-1:0] rword;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [2:0] rcnt = 0, wcnt = 0;
  int mismatches = 0, comparisons = 0, cycles = 0;
  localparam logic [SYM_W-1:0] TRAIN_SYM = {1'b1, TRAINING_PATTERN, 1'b0};

  serial_link_lock_sync dut_u (.i_sys_clk(clk), .i_nrst(nrst), .i_parallel_word_in(word),
    .i_transmit_word_clock(wclk), .i_tx_edge_select(tx_sel), .i_pattern_request_a(req_a),
    .i_pattern_request_b(req_b), .o_link_symbol(tx_sym), .o_link_symbol_valid(tx_vld),
    .i_link_symbol(rx_sym), .i_link_symbol_valid(rx_vld), .i_receiver_reference_clock(receiver_reference_clock),
    .i_rx_edge_select(rx_sel), .i_rx_output_enable(rx_en), .o_lock_lost(lock_lost),
    .o_parallel_word_out(rword), .o_parallel_word_out_oe(oe), .o_rx_word_clk(rclk),
    .o_rx_word_clk_oe(rclk_oe), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq(irq));

  link_partner partner_u (.i_sys_clk(clk), .i_symbol(tx_sym), .i_symbol_valid(tx_vld),
    .o_symbol(rx_sym), .o_symbol_valid(rx_vld));

  // System clock at 10 MHz.
  always #50 clk = ~clk;

  // Reference and word clocks at 800 ns, both driven off the system edge so inputs never race it.
  always @(posedge clk) begin
    if (ref_on) begin
      rcnt <= rcnt + 1;
      if (rcnt == 3'h3) begin
        rcnt <= 0;
        receiver_reference_clock <= ~receiver_reference_clock;
      end
    end
    if (tx_on) begin
      wcnt <= wcnt + 1;
      wclk <= wcnt[2];
    end
    if (tx_vld && tx_sym[10:1] != TRAINING_PATTERN) begin
      vphase <= wcnt[2];
    end
  end

  // Hang guard: the whole run needs about 18000 cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t value %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so it is taken right after that edge.
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: receive lock life cycle first, then the transmit framer and training bursts.
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    chk(lock_lost, 1);
    chk({oe, rclk_oe, irq}, 0);
    reg_rd(REG_LINK_STATE, d);
    chk(d, 32'h0000_0009);
    reg_rd(4'h1, d);
    chk(d, 0);
    reg_rd(REG_IRQ_CLEAR, d);
    chk(d, 0);
    reg_wr(REG_IRQ_ENABLE, 32'h0000_0007);
    reg_rd(REG_IRQ_ENABLE, d);
    chk(d, 32'h0000_0007);
    repeat (4) partner_u.send(TRAIN_SYM);
    chk(lock_lost, 1);
    ref_on <= 1'b1;
    repeat (20) @(posedge clk);
    // The lock indicator is looped back: training goes on while it stays high.
    while (lock_lost === 1'b1 && cycles < 2000) partner_u.send(TRAIN_SYM);
    chk({oe, rclk_oe, irq}, 3'h7);
    reg_rd(REG_IRQ_STATUS, d);
    chk(d, 32'h0000_0001);
    reg_wr(REG_IRQ_CLEAR, 32'h0000_0001);
    reg_rd(REG_IRQ_STATUS, d);
    chk({d[2:0], irq}, 0);
    for (int i = 0; i < 4; i++) begin
      w = 10'h155 + 10'(i * 9);
      partner_u.send({1'b1, w, 1'b0});
      chk(rword, w);
      chk(rclk, rx_sel);
      rx_sel <= i[0];
      repeat (5) @(posedge clk);
    end
    rx_en <= 1'b0;
    repeat (6) @(posedge clk);
    chk({oe, rclk_oe, lock_lost}, 0);
    rx_en <= 1'b1;
    // A good symbol between bad ones restarts the loss count.
    for (int i = 0; i < 7; i++) begin
      partner_u.send(i == 3 ? {1'b1, w, 1'b0} : {1'b0, ~w, 1'b1});
    end
    chk(lock_lost, 0);
    chk(rword, w);
    partner_u.send({1'b0, ~w, 1'b1});
    chk({lock_lost, oe, rclk_oe}, 3'h4);
    chk(irq, 1);
    reg_wr(REG_IRQ_ENABLE, 32'h0000_0000);
    reg_rd(REG_IRQ_STATUS, d);
    chk({d[2:0], irq}, 4'h4);
    reg_wr(REG_IRQ_CLEAR, 32'h0000_0002);
    // Random data lock; still unlocked after 31 good symbols, locked after the 32nd, and no words are compared.
    for (int i = 0; i < 32; i++) begin
      partner_u.send({1'b1, 10'(i * 37 + 5), 1'b0});
      if (i == 30) chk(lock_lost, 1);
    end
    chk(lock_lost, 0);
    tx_on <= 1'b1;
    repeat (80) @(posedge clk);
    chk(partner_u.last_sym, {1'b1, word, 1'b0});
    chk(vphase, 0);
    tx_sel <= 1'b0;
    repeat (40) @(posedge clk);
    chk(vphase, 1);
    partner_u.clear();
    req_a <= 1'b1;
    repeat (40) @(posedge clk);
    reg_rd(REG_LINK_STATE, d);
    chk(d[2], 1);
    req_a <= 1'b0;
    repeat (1040 * 8) @(posedge clk);
    chk(32'(partner_u.train_cnt), 32'(TRAIN_BURST_SYMS));
    reg_rd(REG_IRQ_STATUS, d);
    chk(d[2], 1);
    partner_u.clear();
    req_b <= 1'b1;
    repeat (1100 * 8) @(posedge clk);
    req_b <= 1'b0;
    repeat (80) @(posedge clk);
    chk(32'(partner_u.train_cnt > 1050), 1);
    chk(partner_u.last_sym, {1'b1, word, 1'b0});
    complete_run();
  end
endmodule
